// >>> uspc_pkg.sv
// shared constants and types of the serial port control block
// assumes a byte address bus of eight bits and 32-bit apb data
package uspc_pkg;
	// register byte addresses
	localparam logic [7:0] USPC_ADDR_CTRL = 8'h98;
	localparam logic [7:0] USPC_ADDR_DATA = 8'h9c;
	localparam logic [7:0] USPC_ADDR_BAUD = 8'ha0;
	localparam logic [7:0] USPC_ADDR_ISTAT = 8'ha4;
	localparam logic [7:0] USPC_ADDR_IMASK = 8'ha8;
	localparam logic [7:0] USPC_ADDR_CSET = 8'hac;
	localparam logic [7:0] USPC_ADDR_CCLR = 8'hb0;
	localparam logic [7:0] USPC_ADDR_STAT = 8'hb4;
	// control field positions
	localparam int USPC_WLS = 7;
	localparam int USPC_RSV = 6;
	localparam int USPC_MFE = 5;
	localparam int USPC_REN = 4;
	localparam int USPC_TX9 = 3;
	localparam int USPC_RX9 = 2;
	localparam int USPC_TXD = 1;
	localparam int USPC_RXD = 0;
	// control reset value and writable bits
	localparam logic [7:0] USPC_CTRL_RESET = 8'h40;
	localparam logic [7:0] USPC_CTRL_WMASK = 8'hbf;
	// interrupt status bits
	localparam int USPC_IRQ_W = 3;
	localparam int USPC_IRQ_TX = 0;
	localparam int USPC_IRQ_RX = 1;
	localparam int USPC_IRQ_OVR = 2;
	localparam logic [2:0] USPC_IRQ_RESET = 3'h0;
	// pclk cycles per bit after reset
	localparam logic [15:0] USPC_BAUD_RESET = 16'h0364;
	// data bits per frame
	localparam logic [3:0] USPC_BITS8 = 4'h8;
	localparam logic [3:0] USPC_BITS9 = 4'h9;
	typedef enum logic [1:0] {
		USPC_IDLE = 2'b00,
		USPC_START = 2'b01,
		USPC_DATA = 2'b10,
		USPC_STOP = 2'b11
	} uspc_state_t;
endpackage

// >>> uspc_tx.sv
// transmit framer: start bit, 8 or 9 data bits lsb first, stop bit
// assumes start comes as a one-cycle pulse only while busy is low
`timescale 1ns/1ps
`default_nettype none
module uspc_tx (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic start, // pulse: send one frame
	input wire logic [7:0] data, // byte to send
	input wire logic nine_mode, // 1: nine data bits
	input wire logic ninth, // ninth bit for nine-bit frames
	input wire logic [15:0] bit_cycles, // pclk cycles per bit
	output logic busy, // frame in progress
	output logic done, // pulse at start of stop bit
	output logic txd // serial line, idle high
);
	import uspc_pkg::*;
	uspc_state_t state, next_state;
	logic [15:0] cnt, next_cnt;
	logic [3:0] bitn, next_bitn, nbits, next_nbits;
	logic [8:0] shift, next_shift;
	logic next_done, next_txd;

	assign busy = (state != USPC_IDLE);

	// frame sequencer; the bit count is latched so a mode change mid-frame is harmless
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_bitn = bitn;
		next_nbits = nbits;
		next_shift = shift;
		next_txd = txd;
		next_done = 1'b0;
		unique case (state)
			USPC_IDLE: begin
				next_txd = 1'b1;
				if (start) begin
					next_shift = {ninth, data};
					next_nbits = nine_mode ? USPC_BITS9 : USPC_BITS8;
					next_txd = 1'b0;
					next_cnt = bit_cycles - 16'h0001;
					next_state = USPC_START;
				end
			end
			USPC_START: begin
				if (cnt == 16'h0000) begin
					next_txd = shift[0];
					next_shift = {1'b0, shift[8:1]};
					next_bitn = 4'h1;
					next_cnt = bit_cycles - 16'h0001;
					next_state = USPC_DATA;
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
			USPC_DATA: begin
				if (cnt == 16'h0000) begin
					next_cnt = bit_cycles - 16'h0001;
					if (bitn == nbits) begin
						next_txd = 1'b1;
						next_done = 1'b1;
						next_state = USPC_STOP;
					end else begin
						next_txd = shift[0];
						next_shift = {1'b0, shift[8:1]};
						next_bitn = bitn + 4'h1;
					end
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
			USPC_STOP: begin
				if (cnt == 16'h0000) begin
					next_state = USPC_IDLE;
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
		endcase
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= USPC_IDLE;
			cnt <= 16'h0000;
			bitn <= 4'h0;
			nbits <= USPC_BITS8;
			shift <= 9'h000;
			txd <= 1'b1;
			done <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			bitn <= next_bitn;
			nbits <= next_nbits;
			shift <= next_shift;
			txd <= next_txd;
			done <= next_done;
		end
	end
endmodule
`default_nettype wire

// >>> uspc_rx.sv
// receive framer: samples each bit at its middle, reports at stop sample
// assumes rxd is already synchronised to pclk
`timescale 1ns/1ps
`default_nettype none
module uspc_rx (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic rxd, // synchronised serial line
	input wire logic enable, // 1: a start bit may begin a frame
	input wire logic nine_mode, // 1: nine data bits
	input wire logic [15:0] bit_cycles, // pclk cycles per bit
	output logic done, // pulse at stop bit sample
	output logic [7:0] data, // received byte
	output logic last_bit // ninth bit, or stop bit in 8-bit frames
);
	import uspc_pkg::*;
	uspc_state_t state, next_state;
	logic [15:0] cnt, next_cnt;
	logic [3:0] bitn, next_bitn;
	logic [8:0] shift, next_shift;
	logic mode9, next_mode9, next_done, next_last;
	logic [7:0] next_data;

	// frame sequencer; enable only gates the start, a frame under way completes
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_bitn = bitn;
		next_shift = shift;
		next_mode9 = mode9;
		next_data = data;
		next_last = last_bit;
		next_done = 1'b0;
		unique case (state)
			USPC_IDLE: begin
				if (enable && !rxd) begin
					next_mode9 = nine_mode;
					next_cnt = {1'b0, bit_cycles[15:1]};
					next_state = USPC_START;
				end
			end
			USPC_START: begin
				if (cnt != 16'h0000) begin
					next_cnt = cnt - 16'h0001;
				end else if (rxd) begin
					next_state = USPC_IDLE; // glitch, not a start bit
				end else begin
					next_bitn = 4'h0;
					next_cnt = bit_cycles - 16'h0001;
					next_state = USPC_DATA;
				end
			end
			USPC_DATA: begin
				if (cnt == 16'h0000) begin
					next_shift = {rxd, shift[8:1]};
					next_bitn = bitn + 4'h1;
					next_cnt = bit_cycles - 16'h0001;
					if (next_bitn == (mode9 ? USPC_BITS9 : USPC_BITS8)) begin
						next_state = USPC_STOP;
					end
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
			USPC_STOP: begin
				if (cnt == 16'h0000) begin
					next_done = 1'b1;
					next_data = mode9 ? shift[7:0] : shift[8:1];
					next_last = mode9 ? shift[8] : rxd;
					next_state = USPC_IDLE;
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
		endcase
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= USPC_IDLE;
			cnt <= 16'h0000;
			bitn <= 4'h0;
			shift <= 9'h000;
			mode9 <= 1'b0;
			data <= 8'h00;
			last_bit <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			bitn <= next_bitn;
			shift <= next_shift;
			mode9 <= next_mode9;
			data <= next_data;
			last_bit <= next_last;
			done <= next_done;
		end
	end
endmodule
`default_nettype wire

// >>> uspc_top.sv
// serial port control: apb register file, frame filter, flags and interrupt
// assumes an apb master on pclk and a remote transceiver on tx_out / rx_in
`timescale 1ns/1ps
`default_nettype none
module uspc_top (
	input wire logic pclk, // system clock, 100 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, 1 = write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	output logic irq, // interrupt request, high level
	output logic tx_out, // serial transmit line
	input wire logic rx_in // serial receive line, async
);
	import uspc_pkg::*;

	// control register and its next value
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	// receive buffer
	logic [7:0] rx_buf;
	logic [7:0] next_rx_buf;
	logic rx_full;
	logic next_rx_full;
	// bit time and interrupt mask
	logic [15:0] baud;
	logic [15:0] next_baud;
	logic [2:0] imask;
	logic [2:0] next_imask;
	// sticky interrupt status
	logic [2:0] istat;
	logic [2:0] next_istat;
	// transmit launch
	logic tx_start;
	logic next_tx_start;
	logic [7:0] tx_byte;
	logic [7:0] next_tx_byte;
	// bus response and interrupt next values
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_irq;
	// pin synchroniser and framer connections
	logic rx_meta, rx_sync;
	logic tx_busy, tx_done, tx_line;
	logic rx_done, rx_last;
	logic [7:0] rx_data;
	// decoded transfers and frame events
	logic setup, wr, rd;
	logic wr_ctrl, wr_cset, wr_cclr, wr_data;
	logic wr_baud, wr_imask, rd_data, rd_istat;
	logic rx_pass, rx_take, rx_lost;

	// apb phases; a transfer completes in its first access cycle
	assign setup = psel && !penable;
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;

	// decoded transfers; each is true only in the access cycle that pready marks
	assign wr_ctrl = wr && (paddr == USPC_ADDR_CTRL);
	assign wr_cset = wr && (paddr == USPC_ADDR_CSET);
	assign wr_cclr = wr && (paddr == USPC_ADDR_CCLR);
	assign wr_data = wr && (paddr == USPC_ADDR_DATA);
	assign wr_baud = wr && (paddr == USPC_ADDR_BAUD);
	assign wr_imask = wr && (paddr == USPC_ADDR_IMASK);
	assign rd_data = rd && (paddr == USPC_ADDR_DATA);
	assign rd_istat = rd && (paddr == USPC_ADDR_ISTAT);

	// frame filter on the multidrop bit
	assign rx_pass = rx_done && (!ctrl[USPC_MFE] || rx_last);
	// a full buffer keeps the older byte and only flags the loss
	assign rx_take = rx_pass && !rx_full;
	assign rx_lost = rx_pass && rx_full;

	// two-stage synchroniser for the receive pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= rx_in;
			rx_sync <= rx_meta;
		end
	end

	// transmit framer, ninth bit ignored by it in 8-bit frames
	uspc_tx u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.start(tx_start),
		.data(tx_byte),
		.nine_mode(ctrl[USPC_WLS]),
		.ninth(ctrl[USPC_TX9]),
		.bit_cycles(baud),
		.busy(tx_busy),
		.done(tx_done),
		.txd(tx_line)
	);

	// receive framer, gated by receive enable
	uspc_rx u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.rxd(rx_sync),
		.enable(ctrl[USPC_REN]),
		.nine_mode(ctrl[USPC_WLS]),
		.bit_cycles(baud),
		.done(rx_done),
		.data(rx_data),
		.last_bit(rx_last)
	);

	// bus response; read data is captured in the setup cycle and stands one cycle
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pready = setup;
		next_pslverr = 1'b0;
		// the set and clear aliases read back the control register
		if (setup) begin
			case (paddr)
				USPC_ADDR_CTRL: next_prdata = {24'h00_0000, ctrl};
				USPC_ADDR_CSET: next_prdata = {24'h00_0000, ctrl};
				USPC_ADDR_CCLR: next_prdata = {24'h00_0000, ctrl};
				USPC_ADDR_DATA: next_prdata = {24'h00_0000, rx_buf};
				USPC_ADDR_BAUD: next_prdata = {16'h0000, baud};
				USPC_ADDR_ISTAT: next_prdata = {29'h0000_0000, istat};
				USPC_ADDR_IMASK: next_prdata = {29'h0000_0000, imask};
				USPC_ADDR_STAT: next_prdata = {30'h0000_0000, rx_full, tx_busy};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	// bus response flip-flops; nothing of a response outlives its access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// control register; bit six is forced so it always reads one
	always_comb begin
		next_ctrl = ctrl;
		// the two aliases change only the bits written as one
		if (wr_ctrl) begin
			next_ctrl = (pwdata[7:0] & USPC_CTRL_WMASK) | USPC_CTRL_RESET;
		end else if (wr_cset) begin
			next_ctrl = ctrl | (pwdata[7:0] & USPC_CTRL_WMASK);
		end else if (wr_cclr) begin
			next_ctrl = ctrl & ~(pwdata[7:0] & USPC_CTRL_WMASK);
		end
		// hardware sets come last so they win over a clear in the same cycle
		if (tx_done) begin
			next_ctrl[USPC_TXD] = 1'b1;
		end
		if (rx_take) begin
			next_ctrl[USPC_RX9] = rx_last;
			next_ctrl[USPC_RXD] = 1'b1;
		end
	end

	// control register flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= USPC_CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// bit time and interrupt mask, plain read-write words
	always_comb begin
		next_baud = baud;
		next_imask = imask;
		// a bit time of zero wraps to the longest bit
		if (wr_baud) begin
			next_baud = pwdata[15:0];
		end
		if (wr_imask) begin
			next_imask = pwdata[2:0];
		end
	end

	// bit time and mask flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud <= USPC_BAUD_RESET;
			imask <= USPC_IRQ_RESET;
		end else begin
			baud <= next_baud;
			imask <= next_imask;
		end
	end

	// transmit launch; a byte written while a frame is under way is dropped
	always_comb begin
		next_tx_start = 1'b0;
		next_tx_byte = tx_byte;
		// the pulse itself is checked too, as busy rises one cycle after it
		if (wr_data && !tx_busy && !tx_start) begin
			next_tx_start = 1'b1;
			next_tx_byte = pwdata[7:0];
		end
	end

	// transmit launch flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_start <= 1'b0;
			tx_byte <= 8'h00;
		end else begin
			tx_start <= next_tx_start;
			tx_byte <= next_tx_byte;
		end
	end

	// receive buffer; the full test sees the old state, so a same-cycle read loses
	always_comb begin
		next_rx_buf = rx_buf;
		next_rx_full = rx_full;
		// reading the data word empties the buffer
		if (rd_data) begin
			next_rx_full = 1'b0;
		end
		if (rx_take) begin
			next_rx_buf = rx_data;
			next_rx_full = 1'b1;
		end
	end

	// receive buffer flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf <= 8'h00;
			rx_full <= 1'b0;
		end else begin
			rx_buf <= next_rx_buf;
			rx_full <= next_rx_full;
		end
	end

	// sticky interrupt status; a read clears only the bits that it returned
	always_comb begin
		next_istat = istat;
		if (rd_istat) begin
			next_istat = istat & ~prdata[2:0];
		end
		// events come after the clear so that a set wins
		if (tx_done) begin
			next_istat[USPC_IRQ_TX] = 1'b1;
		end
		if (rx_take) begin
			next_istat[USPC_IRQ_RX] = 1'b1;
		end
		if (rx_lost) begin
			next_istat[USPC_IRQ_OVR] = 1'b1;
		end
		// level interrupt from the next values, without a cycle of lag
		next_irq = |(next_istat & next_imask);
	end

	// status and interrupt flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat <= USPC_IRQ_RESET;
			irq <= 1'b0;
		end else begin
			istat <= next_istat;
			irq <= next_irq;
		end
	end

	// the framer's line output is already a flip-flop
	// it goes straight to the pin, idle high from reset
	assign tx_out = tx_line;
endmodule
`default_nettype wire

// >>> uspc_monitor.sv
// checker of the serial port control block, bound to its top module
// assumes an apb master that holds each request until pready
`timescale 1ns/1ps
`default_nettype none
module uspc_monitor (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // write
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // wdata
	input wire logic [31:0] prdata, // rdata
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic irq, // interrupt
	input wire logic tx_out, // tx line
	input wire logic rx_in // rx line
);
	import uspc_pkg::*;
	logic mapped;
	logic irq_acc;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// the eight words from control to status are the only mapped ones
	assign mapped = paddr >= USPC_ADDR_CTRL && paddr <= USPC_ADDR_STAT && paddr[1:0] == 2'b00;
	// only software touching status or mask may lower the interrupt
	assign irq_acc = pready && (paddr == USPC_ADDR_ISTAT || paddr == USPC_ADDR_IMASK);
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	ready_qual_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	err_decode_a: assert property (pready |-> pslverr == !mapped)
		else $error("wrong error response");
	err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error with data");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	ctrl_reserved_a: assert property (pready && !pwrite && paddr == USPC_ADDR_CTRL
		|-> prdata[USPC_RSV] && prdata[31:8] == 24'h0) else $error("reserved bit low");
	istat_width_a: assert property (pready && !pwrite && paddr == USPC_ADDR_ISTAT
		|-> prdata[31:3] == 29'h0) else $error("status upper bits set");
	irq_hold_a: assert property ($fell(irq) |-> $past(irq_acc) || $past(irq_acc, 2))
		else $error("interrupt dropped by itself");
endmodule
bind uspc_top uspc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .tx_out(tx_out), .rx_in(rx_in));
`default_nettype wire

// >>> uspc_peer.sv
// remote transceiver model on the serial lines of the block
// assumes the bench keeps bc equal to the bit time it programs
`timescale 1ns/1ps
`default_nettype none
module uspc_peer (
	input wire logic pclk, // system clock
	input wire logic line_in, // from the block's transmit line
	output var logic line_out // to the block's receive line
);
	int bc = 8;
	// line idles high between frames
	initial line_out = 1'b1;
	// start bit, nb bits lsb first, then one idle bit time
	task automatic send(input logic [9:0] f, input int nb);
		line_out <= 1'b0;
		repeat (bc) @(posedge pclk);
		for (int i = 0; i < nb; i++) begin
			line_out <= f[i];
			repeat (bc) @(posedge pclk);
		end
		line_out <= 1'b1;
		repeat (bc) @(posedge pclk);
	endtask
	// mid-bit sampling of the ten bit times after the start bit
	task automatic grab(output logic [9:0] f);
		@(negedge line_in);
		repeat (bc / 2) @(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			repeat (bc) @(posedge pclk);
			f[i] = line_in;
		end
	endtask
endmodule
`default_nettype wire

// >>> tb_uart_serial_port_control.sv
// self-checking bench of the serial port control block
// assumes the peer model on the serial lines and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_uart_serial_port_control;
	import uspc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, tx_out, rx_in, e;
	logic [31:0] r;
	logic [9:0] v;
	int failures = 0;
	int num_checks = 0;
	uspc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .tx_out(tx_out), .rx_in(rx_in));
	uspc_peer peer (.pclk(pclk), .line_in(tx_out), .line_out(rx_in));
	// one apb transfer; ready, read data and error are all taken at the rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) failures++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(r, x)
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_regs();
		rdc(USPC_ADDR_CTRL, 32'h40);
		rdc(USPC_ADDR_ISTAT, 32'h0);
		wr(USPC_ADDR_CTRL, 32'h0);
		rdc(USPC_ADDR_CTRL, 32'h40);
		wr(USPC_ADDR_CSET, 32'h28);
		rdc(USPC_ADDR_CTRL, 32'h68);
		wr(USPC_ADDR_CCLR, 32'h20);
		rdc(USPC_ADDR_CTRL, 32'h48);
		apb(1'b0, 8'h10, 32'h0);
		`CHK(e, 1'b1)
		rdc(USPC_ADDR_BAUD, {16'h0, USPC_BAUD_RESET});
		wr(USPC_ADDR_BAUD, 32'h8);
		rdc(USPC_ADDR_BAUD, 32'h8);
		$display("t_regs done");
	endtask
	// every framing and ninth-bit pair, sent and judged at the line
	task automatic t_tx();
		logic [7:0] d;
		logic [7:0] c;
		wr(USPC_ADDR_IMASK, 32'h1);
		for (int m = 0; m < 4; m++) begin
			d = 8'h5a ^ m[7:0];
			c = {m[1], 1'b1, 2'b00, m[0], 3'b000};
			wr(USPC_ADDR_CTRL, {24'h0, c});
			fork
				peer.grab(v);
				wr(USPC_ADDR_DATA, {24'h0, d});
			join
			repeat (12) @(posedge pclk);
			`CHK(v, m[1] ? {1'b1, m[0], d} : {2'b11, d})
			`CHK(irq, 1'b1)
			rdc(USPC_ADDR_ISTAT, 32'h1);
			rdc(USPC_ADDR_CTRL, {24'h0, c | 8'h02});
			wr(USPC_ADDR_CCLR, 32'h2);
			rdc(USPC_ADDR_CTRL, {24'h0, c});
		end
		$display("t_tx done");
	endtask
	// framing, filter and last-bit level in all eight combinations
	task automatic t_rx();
		logic [7:0] c;
		logic acc;
		logic lb;
		wr(USPC_ADDR_IMASK, 32'h2);
		for (int m = 0; m < 8; m++) begin
			lb = m[0];
			acc = !m[1] || lb;
			c = {m[2], 1'b1, m[1], 5'h10};
			wr(USPC_ADDR_CTRL, {24'h0, c});
			peer.send({1'b1, lb, 8'h30 + m[7:0]}, m[2] ? 10 : 9);
			`CHK(irq, acc)
			rdc(USPC_ADDR_ISTAT, {30'h0, acc, 1'b0});
			rdc(USPC_ADDR_CTRL, {24'h0, c | {5'h0, acc & lb, 1'b0, acc}});
			if (acc) rdc(USPC_ADDR_DATA, {24'h0, 8'h30 + m[7:0]});
		end
		$display("t_rx done");
	endtask
	// receive gated off, then a second frame into a full buffer
	task automatic t_ovr();
		wr(USPC_ADDR_CTRL, 32'hc0);
		peer.send(10'h355, 10);
		rdc(USPC_ADDR_CTRL, 32'hc0);
		rdc(USPC_ADDR_ISTAT, 32'h0);
		wr(USPC_ADDR_CTRL, 32'hd0);
		peer.send(10'h311, 10);
		peer.send(10'h222, 10);
		rdc(USPC_ADDR_ISTAT, 32'h6);
		rdc(USPC_ADDR_CTRL, 32'hd5);
		rdc(USPC_ADDR_STAT, 32'h2);
		rdc(USPC_ADDR_DATA, 32'h11);
		rdc(USPC_ADDR_STAT, 32'h0);
		$display("t_ovr done");
	endtask
	// 100 MHz clock
	initial forever #5 pclk = ~pclk;
	// main sequence after eight cycles of reset
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_tx();
		t_rx();
		t_ovr();
		print_verdict();
	end
	// watchdog, far beyond the fewer than two thousand cycles the tests need
	initial begin
		#200000;
		failures++;
		print_verdict();
	end
endmodule
`default_nettype wire
